// ### rtl/rcs_pkg.sv
// Package: register map, field positions and reset values of the reader control and status page
`default_nettype none
package rcs_pkg;
    // Register width and host address width
    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 6;
    // Register offsets
    localparam logic [5:0]  ADDR_CONTROL  = 6'h09;
    localparam logic [5:0]  ADDR_ERROR    = 6'h0a;
    localparam logic [5:0]  ADDR_CLASH    = 6'h0b;
    localparam logic [5:0]  ADDR_COUNT    = 6'h0c;
    localparam logic [5:0]  ADDR_CRC_LO   = 6'h0d;
    localparam logic [5:0]  ADDR_CRC_HI   = 6'h0e;
    // Control field positions
    localparam int          CTL_STANDBY   = 5;
    localparam int          CTL_SLEEP     = 4;
    localparam int          CTL_CIPHER    = 3;
    localparam int          CTL_HALT      = 2;
    localparam int          CTL_GO        = 1;
    localparam int          CTL_PURGE     = 0;
    // Error flag field positions
    localparam int          ERR_KEY       = 6;
    localparam int          ERR_RIGHTS    = 5;
    localparam int          ERR_OVERRUN   = 4;
    localparam int          ERR_CHECK     = 3;
    localparam int          ERR_FRAME     = 2;
    localparam int          ERR_PARITY    = 1;
    localparam int          ERR_CLASH     = 0;
    localparam int          ERR_W         = 7;
    // Reset values
    localparam logic [7:0]  CONTROL_RST   = 8'h00;
    localparam logic [6:0]  ERROR_RST     = 7'h40;
    localparam logic [7:0]  CLASH_RST     = 8'h00;
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;
    // Read-back state of the data port
    typedef enum logic [0:0] {
        RCS_RD_IDLE  = 1'b0,
        RCS_RD_VALID = 1'b1
    } rcs_rd_state_t;
endpackage : rcs_pkg
`default_nettype wire

// ### rtl/rcs_flag_bank.sv
// Module: bank of sticky fault flags with set-over-clear priority
`default_nettype none
module rcs_flag_bank #(
    parameter int             W   = 7,
    parameter logic [W-1:0]   RST = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Per-flag set and clear strobes
    input  wire logic [W-1:0] set_in,
    input  wire logic [W-1:0] clr_in,
    // Flag levels
    output logic [W-1:0]      flags
);
    ////////////////////////////////////////////////////////////////////////////
    // One flip-flop per flag; a set arriving with a clear is never lost
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_flag
            logic flag_r;
            always_ff @(posedge clk) begin
                if (rst) begin
                    flag_r <= RST[i];
                end else if (set_in[i]) begin
                    flag_r <= 1'b1;
                end else if (clr_in[i]) begin
                    flag_r <= 1'b0;
                end
            end
            assign flags[i] = flag_r;
        end
    endgenerate
endmodule : rcs_flag_bank
`default_nettype wire

// ### rtl/rcs_clash_pos.sv
// Module: capture of the first collision position in a received frame, except in type B
`default_nettype none
module rcs_clash_pos (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Frame start, collision event and protocol
    input  wire logic       rx_prepare,
    input  wire logic       collision_hit,
    input  wire logic [7:0] collision_bit,
    input  wire logic       proto_type_b,
    // Held position
    output logic [7:0]      clash_position
);
    logic captured_r;   // First collision of this frame already held

    ////////////////////////////////////////////////////////////////////////////
    // Only the first collision counts; later ones in the frame are ignored
    always_ff @(posedge clk) begin
        if (rst) begin
            clash_position <= rcs_pkg::CLASH_RST;
            captured_r     <= 1'b0;
        end else if (rx_prepare) begin
            // New reception re-arms the capture
            captured_r     <= 1'b0;
        end else if (collision_hit && !captured_r && !proto_type_b) begin
            clash_position <= collision_bit;
            captured_r     <= 1'b1;
        end
    end
endmodule : rcs_clash_pos
`default_nettype wire

// ### rtl/rcs_ctrl_status.sv
// Module: control, fault flag and result registers of the reader status page
`default_nettype none
module rcs_ctrl_status (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Host register port
    input  wire logic [5:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    output logic            reg_rvalid,
    // Command unit events
    input  wire logic       auth_step_two_ok,
    input  wire logic       key_load_start,
    input  wire logic       key_format_bad,
    input  wire logic       eeprom_cmd_start,
    input  wire logic       eeprom_rights_bad,
    // Queue write attempts
    input  wire logic       host_queue_write,
    input  wire logic       int_queue_write,
    input  wire logic       queue_full,
    // Receiver events
    input  wire logic       receive_prepare_state,
    input  wire logic       rx_check_enable,
    input  wire logic       rx_crc_bad,
    input  wire logic       sof_bad,
    input  wire logic       parity_bad,
    input  wire logic       collision_hit,
    input  wire logic [7:0] collision_bit,
    input  wire logic       proto_type_b,
    // Timer and CRC unit values
    input  wire logic [7:0] timer_count,
    input  wire logic [15:0] crc_value,
    input  wire logic       check_result_valid,
    input  wire logic       crc_8bit_mode,
    // Power and cipher controls
    output logic            blocks_off,
    output logic            clock_stop,
    output logic            card_cipher_on,
    output logic            cipher_enable,
    // Command pulses
    output logic            timer_halt_cmd,
    output logic            timer_go_cmd,
    output logic            queue_purge,
    // Fault flags
    output logic            queue_overrun_flag,
    output logic [6:0]      error_flags
);
    ////////////////////////////////////////////////////////////////////////////
    // Decode and stored control bits
    logic                  ctl_wr;          // Host write to control
    logic                  standby_r;       // Standby mode held
    logic                  full_sleep_r;    // Power-down mode held
    logic [6:0]            err_set;         // Flag set strobes
    logic [6:0]            err_clr;         // Flag clear strobes
    logic [7:0]            clash_position;  // First collision index
    logic [7:0]            rdata_nxt;       // Read mux output
    rcs_pkg::rcs_rd_state_t rd_state_r;     // Read answer state

    assign ctl_wr = reg_wr && (reg_addr == rcs_pkg::ADDR_CONTROL);

    ////////////////////////////////////////////////////////////////////////////
    // Power modes
    always_ff @(posedge clk) begin
        if (rst) begin
            standby_r    <= rcs_pkg::CONTROL_RST[rcs_pkg::CTL_STANDBY];
            full_sleep_r <= rcs_pkg::CONTROL_RST[rcs_pkg::CTL_SLEEP];
        end else if (ctl_wr) begin
            standby_r    <= reg_wdata[rcs_pkg::CTL_STANDBY];
            full_sleep_r <= reg_wdata[rcs_pkg::CTL_SLEEP];
        end
    end

    assign blocks_off = standby_r || full_sleep_r;
    // clock stop only in sleep; the host write that clears it must reach us
    // on a clock that the pad logic keeps alive, so only a request leaves here
    assign clock_stop = full_sleep_r;

    ////////////////////////////////////////////////////////////////////////////
    // Cipher state: host may clear it, only authentication may set it
    always_ff @(posedge clk) begin
        if (rst) begin
            card_cipher_on <= rcs_pkg::CONTROL_RST[rcs_pkg::CTL_CIPHER];
        end else if (auth_step_two_ok) begin
            card_cipher_on <= 1'b1;
        end else if (ctl_wr && !reg_wdata[rcs_pkg::CTL_CIPHER]) begin
            // A written one is ignored here
            card_cipher_on <= 1'b0;
        end
    end

    assign cipher_enable = card_cipher_on;

    ////////////////////////////////////////////////////////////////////////////
    // Command pulses, never stored so they always read back as zero
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_halt_cmd <= 1'b0;
            timer_go_cmd   <= 1'b0;
            queue_purge    <= 1'b0;
        end else begin
            timer_halt_cmd <= ctl_wr && reg_wdata[rcs_pkg::CTL_HALT];
            timer_go_cmd   <= ctl_wr && reg_wdata[rcs_pkg::CTL_GO];
            queue_purge    <= ctl_wr && reg_wdata[rcs_pkg::CTL_PURGE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault flag causes
    always_comb begin
        err_set = '0;
        err_clr = '0;
        err_set[rcs_pkg::ERR_KEY]     = key_format_bad;
        err_clr[rcs_pkg::ERR_KEY]     = key_load_start;
        err_set[rcs_pkg::ERR_RIGHTS]  = eeprom_rights_bad;
        err_clr[rcs_pkg::ERR_RIGHTS]  = eeprom_cmd_start;
        err_set[rcs_pkg::ERR_OVERRUN] = (host_queue_write || int_queue_write) && queue_full;
        err_clr[rcs_pkg::ERR_OVERRUN] = queue_purge;
        err_set[rcs_pkg::ERR_CHECK]   = rx_check_enable && rx_crc_bad;
        err_set[rcs_pkg::ERR_FRAME]   = sof_bad;
        err_set[rcs_pkg::ERR_PARITY]  = parity_bad;
        err_set[rcs_pkg::ERR_CLASH]   = collision_hit && !proto_type_b;
        err_clr[rcs_pkg::ERR_CHECK]   = receive_prepare_state;
        err_clr[rcs_pkg::ERR_FRAME]   = receive_prepare_state;
        err_clr[rcs_pkg::ERR_PARITY]  = receive_prepare_state;
        err_clr[rcs_pkg::ERR_CLASH]   = receive_prepare_state && !proto_type_b;
    end

    rcs_flag_bank #(
        .W   (rcs_pkg::ERR_W),
        .RST (rcs_pkg::ERROR_RST)
    ) u_flags (
        .clk    (clk),
        .rst    (rst),
        .set_in (err_set),
        .clr_in (err_clr),
        .flags  (error_flags)
    );

    assign queue_overrun_flag = error_flags[rcs_pkg::ERR_OVERRUN];

    // First collision capture
    rcs_clash_pos u_clash (
        .clk            (clk),
        .rst            (rst),
        .rx_prepare     (receive_prepare_state),
        .collision_hit  (collision_hit),
        .collision_bit  (collision_bit),
        .proto_type_b   (proto_type_b),
        .clash_position (clash_position)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; unmapped offsets answer zero
    always_comb begin
        rdata_nxt = rcs_pkg::ZERO_BYTE;
        case (reg_addr)
            rcs_pkg::ADDR_CONTROL: begin
                rdata_nxt[rcs_pkg::CTL_STANDBY] = standby_r;
                rdata_nxt[rcs_pkg::CTL_SLEEP]   = full_sleep_r;
                rdata_nxt[rcs_pkg::CTL_CIPHER]  = card_cipher_on;
            end
            rcs_pkg::ADDR_ERROR: begin
                rdata_nxt = {1'b0, error_flags};
            end
            rcs_pkg::ADDR_CLASH: begin
                rdata_nxt = clash_position;
            end
            rcs_pkg::ADDR_COUNT: begin
                rdata_nxt = timer_count;
            end
            rcs_pkg::ADDR_CRC_LO: begin
                rdata_nxt = crc_value[7:0];
            end
            // high byte, zero in 8-bit mode
            rcs_pkg::ADDR_CRC_HI: begin
                rdata_nxt = crc_8bit_mode ? rcs_pkg::ZERO_BYTE : crc_value[15:8];
            end
            default: begin
                rdata_nxt = rcs_pkg::ZERO_BYTE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered read answer, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata  <= rcs_pkg::ZERO_BYTE;
            rd_state_r <= rcs_pkg::RCS_RD_IDLE;
        end else begin
            case (rd_state_r)
                rcs_pkg::RCS_RD_IDLE,
                rcs_pkg::RCS_RD_VALID: begin
                    rd_state_r <= reg_rd ? rcs_pkg::RCS_RD_VALID : rcs_pkg::RCS_RD_IDLE;
                    if (reg_rd) begin
                        reg_rdata <= rdata_nxt;
                    end
                end
                default: begin
                    rd_state_r <= rcs_pkg::RCS_RD_IDLE;
                end
            endcase
        end
    end

    assign reg_rvalid = (rd_state_r == rcs_pkg::RCS_RD_VALID);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_standby;
        ctl_wr && reg_wdata[rcs_pkg::CTL_STANDBY]
            |=> blocks_off && (clock_stop == $past(reg_wdata[rcs_pkg::CTL_SLEEP]));
    endproperty
    a_standby: assert property (p_standby) else $error("standby did not gate blocks");

    property p_sleep;
        ctl_wr && reg_wdata[rcs_pkg::CTL_SLEEP] |=> blocks_off && clock_stop;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep did not stop clock");

    property p_cipher_host;
        ctl_wr && !card_cipher_on && !auth_step_two_ok |=> !card_cipher_on;
    endproperty
    a_cipher_host: assert property (p_cipher_host) else $error("host set cipher");

    property p_cipher_auth;
        auth_step_two_ok |=> card_cipher_on && cipher_enable;
    endproperty
    a_cipher_auth: assert property (p_cipher_auth) else $error("auth did not set cipher");

    property p_plain;
        !card_cipher_on |-> !cipher_enable;
    endproperty
    a_plain: assert property (p_plain) else $error("cipher active while off");

    property p_halt;
        ctl_wr && reg_wdata[rcs_pkg::CTL_HALT]
            |=> timer_halt_cmd ##1 (timer_halt_cmd == $past(ctl_wr && reg_wdata[rcs_pkg::CTL_HALT]));
    endproperty
    a_halt: assert property (p_halt) else $error("halt pulse wrong");

    property p_go;
        ctl_wr && reg_wdata[rcs_pkg::CTL_GO] |=> timer_go_cmd;
    endproperty
    a_go: assert property (p_go) else $error("go pulse missing");

    property p_purge;
        ctl_wr && reg_wdata[rcs_pkg::CTL_PURGE] && !err_set[rcs_pkg::ERR_OVERRUN] ##1
            !err_set[rcs_pkg::ERR_OVERRUN] |=> !queue_overrun_flag;
    endproperty
    a_purge: assert property (p_purge) else $error("purge left overrun");

    property p_ctl_read;
        reg_rd && reg_addr == rcs_pkg::ADDR_CONTROL |=> reg_rvalid && reg_rdata[2:0] == 3'h0;
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("command bits read nonzero");

    property p_key;
        key_load_start && !key_format_bad |=> !error_flags[rcs_pkg::ERR_KEY];
    endproperty
    a_key: assert property (p_key) else $error("key fault not cleared");

    property p_rights;
        eeprom_cmd_start && !eeprom_rights_bad |=> !error_flags[rcs_pkg::ERR_RIGHTS];
    endproperty
    a_rights: assert property (p_rights) else $error("rights fault not cleared");

    property p_check;
        rx_check_enable && rx_crc_bad |=> error_flags[rcs_pkg::ERR_CHECK];
    endproperty
    a_check: assert property (p_check) else $error("check fault not set");

    property p_overrun;
        (host_queue_write || int_queue_write) && queue_full |=> queue_overrun_flag;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");

    property p_prepare;
        receive_prepare_state && !proto_type_b && !rx_crc_bad && !sof_bad && !parity_bad && !collision_hit
            |=> error_flags[3:0] == 4'h0;
    endproperty
    a_prepare: assert property (p_prepare) else $error("receive faults not cleared");

    property p_type_b;
        proto_type_b && !receive_prepare_state |=> $stable(clash_position);
    endproperty
    a_type_b: assert property (p_type_b) else $error("clash position moved in type B");

    property p_reset;
        disable iff (1'b0) rst |=> error_flags == rcs_pkg::ERROR_RST;
    endproperty
    a_reset: assert property (p_reset) else $error("error flags reset wrong");

    c_auth:    cover property (auth_step_two_ok ##1 card_cipher_on);
    c_purge:   cover property (queue_overrun_flag ##[1:8] queue_purge);
    c_clash:   cover property (collision_hit && !proto_type_b ##1 error_flags[rcs_pkg::ERR_CLASH]);
    c_read_hi: cover property (reg_rd && reg_addr == rcs_pkg::ADDR_CRC_HI && check_result_valid);
endmodule : rcs_ctrl_status
`default_nettype wire

// ### verif/rcs_host_model.sv
// Host model: strobe-port register master driving the status page
`default_nettype none
module rcs_host_model (
    // Clock
    input  wire logic       clk,
    // Register port towards the device
    output var logic [5:0]  reg_addr,
    output var logic        reg_wr,
    output var logic        reg_rd,
    output var logic [7:0]  reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////////////
    // Idle port at time zero
    initial begin
        reg_addr  = 6'h3f;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // One write; released lines are scrambled so nothing leans on stale data
    task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : write_reg
    // One read; the answer lands on the taking edge and is sampled 1 ns after it
    task automatic read_reg(input logic [5:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        ok = (reg_rvalid === 1'b1);
        d  = reg_rdata;
    endtask : read_reg
endmodule : rcs_host_model
`default_nettype wire

// ### verif/reader_control_status_page_tb.sv
// Testbench: status page against a flag and register model
`default_nettype none
module reader_control_status_page_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // Design ports
    logic clk, rst, reg_wr, reg_rd, reg_rvalid, auth_step_two_ok, key_load_start, key_format_bad;
    logic eeprom_cmd_start, eeprom_rights_bad, host_queue_write, int_queue_write, queue_full;
    logic receive_prepare_state, rx_check_enable, rx_crc_bad, sof_bad, parity_bad, collision_hit;
    logic proto_type_b, check_result_valid, crc_8bit_mode, blocks_off, clock_stop, card_cipher_on;
    logic cipher_enable, timer_halt_cmd, timer_go_cmd, queue_purge, queue_overrun_flag;
    logic [5:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, collision_bit, timer_count;
    logic [15:0] crc_value;
    logic [6:0]  error_flags;
    // Model state and draws
    logic [31:0] ev;
    logic [7:0]  cb, cp;
    logic [6:0]  ef, clr, setm;
    logic        pr, tb_b, col, arm;
    int          errors, checks, i;
    ////////////////////////////////////////////////////////////////////////
    rcs_ctrl_status dut (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
        .auth_step_two_ok, .key_load_start, .key_format_bad, .eeprom_cmd_start, .eeprom_rights_bad,
        .host_queue_write, .int_queue_write, .queue_full, .receive_prepare_state, .rx_check_enable,
        .rx_crc_bad, .sof_bad, .parity_bad, .collision_hit, .collision_bit, .proto_type_b, .timer_count,
        .crc_value, .check_result_valid, .crc_8bit_mode, .blocks_off, .clock_stop, .card_cipher_on,
        .cipher_enable, .timer_halt_cmd, .timer_go_cmd, .queue_purge, .queue_overrun_flag, .error_flags);
    rcs_host_model host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid);
    ////////////////////////////////////////////////////////////////////////
    // Compare and verdict
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        if (errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // Read through the host and compare valid and data
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host.read_reg(a, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask : rd_chk
    // Drop every event pulse; queue full is only raised for one attempt
    task automatic clear_events;
        auth_step_two_ok <= 1'b0; key_load_start <= 1'b0; key_format_bad <= 1'b0;
        eeprom_cmd_start <= 1'b0; eeprom_rights_bad <= 1'b0; host_queue_write <= 1'b0;
        int_queue_write <= 1'b0; queue_full <= 1'b0; receive_prepare_state <= 1'b0;
        rx_crc_bad <= 1'b0; sof_bad <= 1'b0; parity_bad <= 1'b0; collision_hit <= 1'b0;
    endtask : clear_events
    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        $display("ERROR t=%0t run did not finish", $time);
        report_and_stop;
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1; errors = 0; checks = 0; clear_events;
        {rx_check_enable, collision_bit, proto_type_b, timer_count, crc_value} = '0;
        {check_result_valid, crc_8bit_mode, tb_b, arm, cp} = '0;
        ev = $urandom(87681);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_chk(rcs_pkg::ADDR_CONTROL, 8'h00);
        rd_chk(rcs_pkg::ADDR_ERROR, 8'h40);
        rd_chk(rcs_pkg::ADDR_CLASH, 8'h00);
        rd_chk(6'h00, 8'h00);
        // All control bits at once: pulses for one cycle, cipher refused
        host.write_reg(rcs_pkg::ADDR_CONTROL, 8'h3f);
        #1 chk({5'h00, timer_halt_cmd, timer_go_cmd, queue_purge}, 8'h07);
        @(posedge clk);
        #1 chk({5'h00, timer_halt_cmd, timer_go_cmd, queue_purge}, 8'h00);
        rd_chk(rcs_pkg::ADDR_CONTROL, 8'h30);
        chk({6'h00, blocks_off, clock_stop}, 8'h03);
        host.write_reg(rcs_pkg::ADDR_CONTROL, 8'h20);
        #1 chk({6'h00, blocks_off, clock_stop}, 8'h02);
        host.write_reg(rcs_pkg::ADDR_CONTROL, 8'h00);
        #1 chk({6'h00, blocks_off, clock_stop}, 8'h00);
        // Cipher only from a successful second authentication step
        @(posedge clk) auth_step_two_ok <= 1'b1;
        @(posedge clk) auth_step_two_ok <= 1'b0;
        #1 chk({6'h00, card_cipher_on, cipher_enable}, 8'h03);
        rd_chk(rcs_pkg::ADDR_CONTROL, 8'h08);
        host.write_reg(rcs_pkg::ADDR_CONTROL, 8'h00);
        #1 chk({6'h00, card_cipher_on, cipher_enable}, 8'h00);
        // Random event storm; set wins over clear in the model too
        ef = 7'h40;
        for (i = 0; i < 60; i++) begin
            ev = $urandom;
            cb = 8'($urandom % 9);
            pr = (i == 0) | (ev[0] & ev[1]);
            if (pr) tb_b = ev[2];
            col = ev[3] & ~pr;
            @(posedge clk);
            receive_prepare_state <= pr; proto_type_b <= tb_b; key_load_start <= ev[4];
            key_format_bad <= ev[5]; eeprom_cmd_start <= ev[6]; eeprom_rights_bad <= ev[7];
            host_queue_write <= ev[8]; int_queue_write <= ev[9]; queue_full <= ev[10];
            rx_check_enable <= ev[11]; rx_crc_bad <= ev[12]; sof_bad <= ev[13]; parity_bad <= ev[14];
            collision_hit <= col; collision_bit <= cb;
            clr  = {ev[4], ev[6], 1'b0, pr, pr, pr, pr & ~tb_b};
            setm = {ev[5], ev[7], (ev[8] | ev[9]) & ev[10], ev[11] & ev[12], ev[13], ev[14], col & ~tb_b};
            ef = (ef & ~clr) | setm;
            if (pr) arm = 1'b1;
            if (col && !tb_b && arm) begin
                cp  = cb;
                arm = 1'b0;
            end
            @(posedge clk) clear_events;
            #1 chk({1'b0, error_flags}, {1'b0, ef});
            chk({7'h00, queue_overrun_flag}, {7'h00, ef[4]});
            rd_chk(rcs_pkg::ADDR_ERROR, {1'b0, ef});
            rd_chk(rcs_pkg::ADDR_CLASH, cp);
        end
        // Reset in mid-run brings the flags and the clash position back
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        ef = 7'h40;
        cp = 8'h00;
        rd_chk(rcs_pkg::ADDR_ERROR, {1'b0, ef});
        rd_chk(rcs_pkg::ADDR_CLASH, cp);
        // Overrun raised by a host write into a full queue, then purged
        @(posedge clk) {host_queue_write, queue_full} <= 2'b11;
        @(posedge clk) clear_events;
        ef[4] = 1'b1;
        rd_chk(rcs_pkg::ADDR_ERROR, {1'b0, ef});
        host.write_reg(rcs_pkg::ADDR_CONTROL, 8'h01);
        ef[4] = 1'b0;
        rd_chk(rcs_pkg::ADDR_ERROR, {1'b0, ef});
        chk({7'h00, queue_overrun_flag}, 8'h00);
        // Live timer and CRC bytes; high byte blank in 8-bit mode
        for (i = 0; i < 4; i++) begin
            ev = $urandom;
            @(posedge clk);
            timer_count <= ev[7:0]; crc_value <= ev[23:8]; crc_8bit_mode <= i[0]; check_result_valid <= 1'b1;
            rd_chk(rcs_pkg::ADDR_COUNT, ev[7:0]);
            rd_chk(rcs_pkg::ADDR_CRC_LO, ev[15:8]);
            rd_chk(rcs_pkg::ADDR_CRC_HI, i[0] ? 8'h00 : ev[23:16]);
        end
        report_and_stop;
    end
endmodule : reader_control_status_page_tb
`default_nettype wire
